// >>> spfc_pkg.sv
// Shared constants and types for the SPI target frame logic
// Behaviour
// - Frame bits 6..0 carry the register address.
// - Bit 7 picks read versus clear (status) or read versus write (control).
// - Bits 23..8 form a 16-bit payload; accesses act on whole words.
// - Status bits stay set until the host clears them.
// - In restart state no received frame is interpreted.
// - An addressed status register is returned in the same frame.
// - Writes act at chip select rising; new value shows next frame.
// - Stop state accepts only return-to-normal and watchdog writes, reads and clears.
// - Status changes late in a frame show in the next status byte.
// - Status byte bits 0, 1, 3: supply, thermal, wake register ORs.
// - Byte bits 5, 6, 7: device (bits 13..0 only), bridge drain-source, failure ORs.
// - Frame bits 31..24 hold an 8-bit CRC on command and response.
// - CRC8: polynomial 2F, init FF, no reflection, final XOR FF.
// - CRC covers frame bits 0..23 in both directions.
// - Control register payload returned is the previously written data.
// - Host sends A5 with CRC off; bad CRC or pattern sets CRC failure.
// - With CRC off every response carries 5A in bits 31..24.
// - Device status reads skip the CRC check; CRC state follows activation.
// - Control registers: 01..0B and 10..1D; bit 7 set writes.
// - Status registers: 40..46 and 50..5B; identification at 70.
// - Clear with bit 7 set; wake level and identification ignore clears.
// - Mode changes update mode bits; sleep entry modifies control bits.
// - Sample input on falling clock, shift output after rising clock.
// - Frames with clock count not 0 or 32 are dropped and flagged next.
package spfc_pkg;

  localparam int FRAME_BITS = 32;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int CRC_W = 8;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;

  localparam int F_RW_BIT = 7;
  localparam int F_DATA_LSB = 8;
  localparam int F_CRC_LSB = 24;
  localparam logic [CNT_W-1:0] PL_LATCH_IDX = 6'h07;

  localparam logic [7:0] CRC_POLY = 8'h2F;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] CRC_XOROUT = 8'hFF;
  localparam logic [7:0] SDI_PATTERN = 8'hA5;
  localparam logic [7:0] SDO_PATTERN = 8'h5A;

  localparam int SB_SUP = 0;
  localparam int SB_THERM = 1;
  localparam int SB_RSV_A = 2;
  localparam int SB_WAKE = 3;
  localparam int SB_RSV_B = 4;
  localparam int SB_DEV = 5;
  localparam int SB_BRIDGE = 6;
  localparam int SB_FAIL = 7;
  localparam logic [DATA_W-1:0] DEV_SUM_MASK = 16'h3FFF;

  localparam logic [ADDR_W-1:0] CTRL_DEV_LO = 7'h01;
  localparam logic [ADDR_W-1:0] CTRL_DEV_HI = 7'h0B;
  localparam logic [ADDR_W-1:0] CTRL_BR_LO = 7'h10;
  localparam logic [ADDR_W-1:0] CTRL_BR_HI = 7'h1D;
  localparam logic [ADDR_W-1:0] STAT_DEV_LO = 7'h40;
  localparam logic [ADDR_W-1:0] STAT_DEV_HI = 7'h46;
  localparam logic [ADDR_W-1:0] STAT_BR_LO = 7'h50;
  localparam logic [ADDR_W-1:0] STAT_BR_HI = 7'h5B;
  localparam logic [ADDR_W-1:0] FAM_PROD_ADDR = 7'h70;
  localparam logic [ADDR_W-1:0] MODE_REG_ADDR = 7'h01;
  localparam logic [ADDR_W-1:0] WDOG_REG_ADDR = 7'h03;
  localparam logic [ADDR_W-1:0] DEV_STAT_ADDR = 7'h43;
  localparam logic [ADDR_W-1:0] WAKE_LVL_ADDR = 7'h46;
  localparam int MODE_FLD_LSB = 14;
  localparam logic [1:0] MODE_CMD_NORMAL = 2'h0;

  typedef enum logic [2:0] {
    MD_INIT = 3'b000,
    MD_NORMAL = 3'b001,
    MD_STOP = 3'b010,
    MD_SLEEP = 3'b011,
    MD_RESTART = 3'b100,
    MD_FAILSAFE = 3'b101
  } spfc_mode_t;

  typedef enum logic {
    FR_IDLE = 1'b0,
    FR_BUSY = 1'b1
  } spfc_fr_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic clear;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } spfc_cmd_t;

  typedef struct packed {
    logic [DATA_W-1:0] supply;
    logic [DATA_W-1:0] thermal;
    logic [DATA_W-1:0] wake;
    logic [DATA_W-1:0] device;
    logic [DATA_W-1:0] bridge;
  } spfc_stat_t;

endpackage

// >>> spfc_crc8.sv
// CRC8 over the low 24 frame bits, three bytes MSB first
`timescale 1ns/10ps
module spfc_crc8 (
  // Frame bits 23..0
  input wire logic [23:0] i_data,
  // Check byte
  output logic [7:0] o_crc
);
  import spfc_pkg::*;

  // Bytes taken low byte first, each byte MSB first, no reflection
  always_comb begin
    logic [7:0] c;
    logic fb;
    fb = 1'b0;
    c = CRC_INIT;
    for (int b = 0; b < 3; b++) begin
      for (int k = 7; k >= 0; k--) begin
        fb = c[7] ^ i_data[8*b+k];
        c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
      end
    end
    o_crc = c ^ CRC_XOROUT;
  end

endmodule // spfc_crc8

// >>> spfc_spi_target.sv
// SPI target: frame capture, CRC, permissions, status byte, response
`timescale 1ns/10ps
module spfc_spi_target #(
  parameter int FRAME_LEN = spfc_pkg::FRAME_BITS
) (
  // System
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // SPI pins
  input wire logic i_sclk,
  input wire logic i_chip_select_low_b,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  // Device state
  input wire logic i_crc_en_pin,
  input wire spfc_pkg::spfc_mode_t i_mode,
  input wire logic i_cmd_fail,
  input wire spfc_pkg::spfc_stat_t i_stat,
  // Register file, read side runs on the SPI clock
  output logic [spfc_pkg::ADDR_W-1:0] o_rd_addr,
  input wire logic [spfc_pkg::DATA_W-1:0] i_rd_data,
  // Register file, command side on i_mclk
  output spfc_pkg::spfc_cmd_t o_cmd,
  output logic o_crc_stat,
  output logic o_crc_fail,
  output logic o_spi_fail,
  output logic o_mode_chg,
  output logic o_sleep_entry
);
  import spfc_pkg::*;

  if (FRAME_LEN != FRAME_BITS) begin : g_bad_len
    $error("FRAME_LEN must equal the 32-bit frame");
  end

  function automatic logic is_ctrl(input logic [ADDR_W-1:0] a);
    is_ctrl = (a >= CTRL_DEV_LO && a <= CTRL_DEV_HI) ||
              (a >= CTRL_BR_LO && a <= CTRL_BR_HI);
  endfunction

  function automatic logic is_stat(input logic [ADDR_W-1:0] a);
    is_stat = (a >= STAT_DEV_LO && a <= STAT_DEV_HI) ||
              (a >= STAT_BR_LO && a <= STAT_BR_HI) ||
              (a == FAM_PROD_ADDR);
  endfunction

  function automatic logic no_clear(input logic [ADDR_W-1:0] a);
    no_clear = (a == WAKE_LVL_ADDR) || (a == FAM_PROD_ADDR);
  endfunction

  wire cs_pin = i_chip_select_low_b;

  // ---- Link domain (SPI clock) ----
  // Link flops have no clock outside frames, so the chip select pin
  // forces the start state of first_r and tx_idx_r without a clock.
  logic first_r;
  logic [CNT_W-1:0] cnt_r;
  logic [FRAME_BITS-1:0] rx_r;
  logic seq_r;
  logic [CNT_W-1:0] tx_idx_r;
  logic sdo_r;
  logic [DATA_W-1:0] pl_r;
  logic [7:0] stat_r;
  logic err_r;
  logic crc_stat_r;

  wire [CNT_W-1:0] rx_idx = first_r ? '0 : cnt_r;
  wire rx_room = rx_idx < CNT_W'(FRAME_BITS);
  wire [CNT_W-1:0] cnt_nxt = (cnt_r == CNT_MAX && !first_r) ?
                             cnt_r : rx_idx + CNT_W'(1);

  always_ff @(negedge i_sclk or posedge cs_pin) begin
    if (cs_pin) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  // Input sampled on falling edges while selected
  always_ff @(negedge i_sclk) begin
    if (!cs_pin) begin
      cnt_r <= cnt_nxt;
      if (rx_room) begin
        rx_r[rx_idx[4:0]] <= i_sdi;
      end
    end
  end

  // Frame-had-clocks toggle; needs its own reset as the clock may idle
  always_ff @(negedge i_sclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seq_r <= 1'b0;
    end else if (!cs_pin && first_r) begin
      seq_r <= ~seq_r;
    end
  end

  always_ff @(posedge i_sclk or posedge cs_pin) begin
    if (cs_pin) begin
      tx_idx_r <= '0;
    end else if (tx_idx_r != CNT_MAX) begin
      tx_idx_r <= tx_idx_r + CNT_W'(1);
    end
  end

  // Response word: status byte, payload, check byte
  logic [7:0] tx_crc_calc;
  wire [7:0] tx_crc = crc_stat_r ? tx_crc_calc : SDO_PATTERN;
  wire [FRAME_BITS-1:0] tx_word = {tx_crc, pl_r, stat_r};
  wire tx_room = tx_idx_r < CNT_W'(FRAME_BITS);

  spfc_crc8 u_tx_crc (
    .i_data({pl_r, stat_r}),
    .o_crc(tx_crc_calc)
  );

  // Output shifted after rising edges; payload taken once the
  // address is in, in time for bit 8
  always_ff @(posedge i_sclk) begin
    if (!cs_pin) begin
      sdo_r <= tx_room ? tx_word[tx_idx_r[4:0]] : 1'b0;
      if (tx_idx_r == PL_LATCH_IDX) begin
        pl_r <= i_rd_data;
      end
    end
  end

  assign o_rd_addr = rx_r[ADDR_W-1:0];
  // Error level shows before the first rising edge
  assign o_sdo = (tx_idx_r == '0) ? err_r : sdo_r;
  assign o_sdo_oe = ~cs_pin;

  // ---- Core domain (i_mclk) ----
  logic cs_s1_r, cs_s2_r;
  logic sq_s1_r, sq_s2_r, sq_seen_r;
  logic ce_s1_r;
  spfc_fr_t fr_r, fr_nxt;
  logic crc_fail_r, spi_fail_r;
  spfc_cmd_t cmd_r;
  spfc_mode_t mode_d_r;
  logic mode_chg_r, sleep_ent_r;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      sq_s1_r <= 1'b0;
      sq_s2_r <= 1'b0;
      ce_s1_r <= 1'b0;
      crc_stat_r <= 1'b0;
    end else begin
      cs_s1_r <= cs_pin;
      cs_s2_r <= cs_s1_r;
      sq_s1_r <= seq_r;
      sq_s2_r <= sq_s1_r;
      ce_s1_r <= i_crc_en_pin;
      crc_stat_r <= ce_s1_r;
    end
  end

  always_comb begin
    fr_nxt = fr_r;
    unique case (fr_r)
      FR_IDLE: if (!cs_s2_r) fr_nxt = FR_BUSY;
      FR_BUSY: if (cs_s2_r) fr_nxt = FR_IDLE;
    endcase
  end

  // Frame fields; stable here because the link clock is gated by
  // chip select and the core only reads them after it has risen
  wire fr_end = (fr_r == FR_BUSY) && cs_s2_r;
  wire clocked = sq_s2_r != sq_seen_r;
  wire good_len = cnt_r == CNT_W'(FRAME_LEN);
  wire [ADDR_W-1:0] rx_addr = rx_r[ADDR_W-1:0];
  wire rx_rw = rx_r[F_RW_BIT];
  wire [DATA_W-1:0] rx_data = rx_r[F_CRC_LSB-1:F_DATA_LSB];
  wire [CRC_W-1:0] rx_crc = rx_r[FRAME_BITS-1:F_CRC_LSB];
  logic [7:0] rx_crc_calc;

  spfc_crc8 u_rx_crc (
    .i_data(rx_r[F_CRC_LSB-1:0]),
    .o_crc(rx_crc_calc)
  );

  wire crc_ok = crc_stat_r ? (rx_crc == rx_crc_calc)
                           : (rx_crc == SDI_PATTERN);
  wire crc_exempt = (rx_addr == DEV_STAT_ADDR) && !rx_rw;
  wire spi_on = (i_mode == MD_INIT) || (i_mode == MD_NORMAL) ||
                (i_mode == MD_STOP);
  wire len_bad = fr_end && clocked && !good_len;
  wire frame_ok = fr_end && clocked && good_len && spi_on;
  wire crc_bad = frame_ok && !crc_ok && !crc_exempt;
  wire accept = frame_ok && (crc_ok || crc_exempt);

  wire wr_req = rx_rw && is_ctrl(rx_addr);
  wire clr_req = rx_rw && is_stat(rx_addr) && !no_clear(rx_addr);
  wire to_normal = rx_data[MODE_FLD_LSB+1:MODE_FLD_LSB] == MODE_CMD_NORMAL;
  wire stop_ok = (rx_addr == WDOG_REG_ADDR) ||
                 ((rx_addr == MODE_REG_ADDR) && to_normal);
  wire wr_allowed = (i_mode == MD_INIT) || (i_mode == MD_NORMAL) ||
                    ((i_mode == MD_STOP) && stop_ok);
  wire wr_refused = accept && wr_req && !wr_allowed;
  wire clr_dev = accept && clr_req && (rx_addr == DEV_STAT_ADDR);

  // Hardware set wins over a host clear in the same cycle
  wire crc_fail_nxt = crc_bad | (crc_fail_r & ~clr_dev);
  wire spi_fail_nxt = wr_refused | i_cmd_fail |
                      (spi_fail_r & ~clr_dev);
  // Error survives zero-clock peeks, ends after the next clocked frame
  wire err_nxt = len_bad | (err_r & ~(fr_end & clocked));

  spfc_cmd_t cmd_nxt;
  always_comb begin
    cmd_nxt = '0;
    cmd_nxt.valid = accept && !wr_refused;
    cmd_nxt.write = wr_req;
    cmd_nxt.clear = clr_req;
    cmd_nxt.addr = rx_addr;
    cmd_nxt.data = rx_data;
  end

  logic [7:0] sb_nxt;
  always_comb begin
    sb_nxt = 8'h00;
    sb_nxt[SB_SUP] = |i_stat.supply;
    sb_nxt[SB_THERM] = |i_stat.thermal;
    sb_nxt[SB_WAKE] = |i_stat.wake;
    sb_nxt[SB_DEV] = |(i_stat.device & DEV_SUM_MASK);
    sb_nxt[SB_BRIDGE] = |i_stat.bridge;
    sb_nxt[SB_FAIL] = spi_fail_r | crc_fail_r;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      fr_r <= FR_IDLE;
      sq_seen_r <= 1'b0;
      crc_fail_r <= 1'b0;
      spi_fail_r <= 1'b0;
      err_r <= 1'b0;
      cmd_r <= '0;
      stat_r <= 8'h00;
    end else begin
      fr_r <= fr_nxt;
      if (fr_end) begin
        sq_seen_r <= sq_s2_r;
      end
      crc_fail_r <= crc_fail_nxt;
      spi_fail_r <= spi_fail_nxt;
      err_r <= err_nxt;
      cmd_r <= cmd_nxt;
      // Frozen during a frame: the link reads it with no clock of ours
      if (fr_r == FR_IDLE && cs_s2_r) begin
        stat_r <= sb_nxt;
      end
    end
  end

  // Mode tracking for the register file
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      mode_d_r <= MD_INIT;
      mode_chg_r <= 1'b0;
      sleep_ent_r <= 1'b0;
    end else begin
      mode_d_r <= i_mode;
      mode_chg_r <= i_mode != mode_d_r;
      sleep_ent_r <= (i_mode == MD_SLEEP) && (mode_d_r != MD_SLEEP);
    end
  end

  assign o_cmd = cmd_r;
  assign o_crc_stat = crc_stat_r;
  assign o_crc_fail = crc_fail_r;
  assign o_spi_fail = spi_fail_r;
  assign o_mode_chg = mode_chg_r;
  assign o_sleep_entry = sleep_ent_r;

  // ---- Checks ----
  a_bad_len_flag: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    len_bad |=> err_r && !cmd_r.valid)
    else $error("bad clock count not flagged or not dropped");

  a_err_holds: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (err_r && !(fr_end && clocked)) |=> err_r)
    else $error("error flag lost before next clocked frame");

  a_restart_quiet: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (fr_end && i_mode == MD_RESTART) |=> !cmd_r.valid && !crc_fail_r
      || $past(crc_fail_r))
    else $error("frame interpreted in restart state");

  a_stop_write: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (cmd_r.valid && cmd_r.write && $past(i_mode) == MD_STOP) |->
      (cmd_r.addr == WDOG_REG_ADDR || cmd_r.addr == MODE_REG_ADDR))
    else $error("write accepted in stop state");

  a_refuse_fail: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    wr_refused |=> spi_fail_r && !cmd_r.valid)
    else $error("refused write not reported");

  a_crc_bad_set: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    crc_bad |=> crc_fail_r ##1 (crc_fail_r || $past(clr_dev)))
    else $error("CRC failure not raised");

  a_crc_sticky: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (crc_fail_r && !clr_dev) |=> crc_fail_r)
    else $error("CRC failure dropped without clear");

  a_cmd_at_end: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    cmd_r.valid |-> $past(fr_end) && cs_s2_r)
    else $error("command issued outside frame end");

  a_clear_range: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (cmd_r.valid && cmd_r.clear) |->
      is_stat(cmd_r.addr) && !no_clear(cmd_r.addr))
    else $error("clear issued to a non-clearable address");

  a_byte_reserved: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    !stat_r[SB_RSV_A] && !stat_r[SB_RSV_B])
    else $error("reserved status byte bit set");

  a_byte_frozen: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (fr_r == FR_BUSY) |=> $stable(stat_r))
    else $error("status byte changed inside a frame");

  a_byte_fail: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (fr_r == FR_IDLE && cs_s2_r) ##1 (fr_r == FR_IDLE) |->
      stat_r[SB_FAIL] == $past(spi_fail_r || crc_fail_r))
    else $error("failure bit of status byte wrong");

endmodule // spfc_spi_target

// >>> spfc_host.sv
// Host SPI controller model driving the target's pins
`timescale 1ns/10ps
module spfc_host (
  // SPI pins
  output logic o_sclk,
  output logic o_chip_select_low_b,
  output logic o_sdi,
  input wire logic i_sdo,
  input wire logic i_sdo_oe
);
  logic last_r;
  // Released line shows the inverse of the last bit, never a stale copy
  wire line = i_sdo_oe ? i_sdo : ~last_r;
  initial begin
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    last_r = 1'b0;
    // Late rise so the link flops surely see their start edge
    #1 o_chip_select_low_b = 1'b1;
  end
  // Clock idles low and stands still between frames
  task automatic frame(input logic [31:0] w, input int n,
                       output logic err, output logic [31:0] rsp);
    rsp = 32'h0;
    o_chip_select_low_b = 1'b0;
    #20;
    err = line;
    for (int k = 0; k < n; k++) begin
      o_sdi = w[k];
      #7 o_sclk = 1'b1;
      #15 o_sclk = 1'b0;
      rsp[k] = line;
      last_r = line;
      #8;
    end
    #20 o_chip_select_low_b = 1'b1;
    #100;
  endtask
endmodule // spfc_host

// >>> tb.sv
// Self-checking bench for the SPI target frame logic
`timescale 1ns/10ps
module tb;
  import spfc_pkg::*;
  logic i_mclk, i_rst_b, i_crc_en_pin, i_cmd_fail;
  spfc_mode_t i_mode;
  spfc_stat_t i_stat;
  spfc_cmd_t cmd, last_cmd;
  wire sclk, cs_b, sdi, sdo, sdo_oe, crc_stat, crc_fail, spi_fail;
  wire mode_chg, sleep_entry;
  wire [ADDR_W-1:0] rd_addr;
  wire [DATA_W-1:0] rd_data = {9'h000, rd_addr} ^ 16'hC3A5;
  int mismatches = 0, comparisons = 0, cyc = 0, ncmd = 0, nchg = 0, nslp = 0;
  bit m_crc_fail = 0, m_spi_fail = 0, m_err = 0;

  spfc_host spfc_host_i (.o_sclk(sclk), .o_chip_select_low_b(cs_b),
    .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe(sdo_oe));
  spfc_spi_target spfc_spi_target_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_sclk(sclk), .i_chip_select_low_b(cs_b), .i_sdi(sdi), .o_sdo(sdo),
    .o_sdo_oe(sdo_oe), .i_crc_en_pin(i_crc_en_pin), .i_mode(i_mode),
    .i_cmd_fail(i_cmd_fail), .i_stat(i_stat), .o_rd_addr(rd_addr),
    .i_rd_data(rd_data), .o_cmd(cmd), .o_crc_stat(crc_stat),
    .o_crc_fail(crc_fail), .o_spi_fail(spi_fail), .o_mode_chg(mode_chg),
    .o_sleep_entry(sleep_entry));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cmd.valid === 1'b1) begin
      ncmd++;
      last_cmd = cmd;
    end
    if (mode_chg === 1'b1) nchg++;
    if (sleep_entry === 1'b1) nslp++;
    if (cyc == 30000) begin
      mismatches++;
      final_report();
    end
  end

  // Own CRC8, bytes low first, each MSB first
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 0; i < 3; i++)
      for (int j = 7; j >= 0; j--)
        c = (c[7] ^ d[8*i+j]) ? {c[6:0], 1'b0} ^ 8'h2F : {c[6:0], 1'b0};
    return c ^ 8'hFF;
  endfunction
  function automatic logic [15:0] rnd16();
    return ($urandom % 2) ? 16'($urandom) : 16'h0000;
  endfunction

  task automatic chk_val(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Data field is only defined for writes
  task automatic chk_cmd(input spfc_cmd_t e, input spfc_cmd_t g);
    comparisons++;
    if (g[25:16] !== e[25:16] || (e.write && g.data !== e.data)) begin
      mismatches++;
      $display("MISMATCH cmd expected %h seen %h", e, g);
    end
  endtask

  task automatic xfer(input logic [6:0] a, input logic rw,
                      input logic [15:0] d, input logic bad);
    logic [31:0] w, rsp, er;
    logic [7:0] sb;
    logic err, live, crcok, ctl, st, wr, clr, stopbad, ok;
    int n0;
    @(posedge i_mclk) #1 i_stat = {rnd16(), rnd16(), rnd16(), rnd16(), rnd16()};
    repeat (4) @(posedge i_mclk);
    w[23:0] = {d, rw, a};
    w[31:24] = i_crc_en_pin ? crc8(w[23:0]) : 8'hA5;
    if (bad) w[31:24] = w[31:24] ^ 8'h01;
    sb = {m_crc_fail | m_spi_fail, |i_stat.bridge,
          |(i_stat.device & DEV_SUM_MASK), 1'b0, |i_stat.wake, 1'b0,
          |i_stat.thermal, |i_stat.supply};
    er[23:0] = {{9'h000, a} ^ 16'hC3A5, sb};
    er[31:24] = i_crc_en_pin ? crc8(er[23:0]) : 8'h5A;
    n0 = ncmd;
    #1 spfc_host_i.frame(w, 32, err, rsp);
    repeat (20) @(posedge i_mclk);
    live = !(i_mode inside {MD_RESTART, MD_SLEEP, MD_FAILSAFE});
    crcok = (a == DEV_STAT_ADDR && !rw) || !bad;
    ctl = (a >= CTRL_DEV_LO && a <= CTRL_DEV_HI) ||
          (a >= CTRL_BR_LO && a <= CTRL_BR_HI);
    st = ((a >= STAT_DEV_LO && a <= STAT_DEV_HI) ||
          (a >= STAT_BR_LO && a <= STAT_BR_HI)) && a != WAKE_LVL_ADDR;
    wr = ctl && rw;
    clr = st && rw;
    stopbad = i_mode == MD_STOP && wr && !(a == WDOG_REG_ADDR ||
              (a == MODE_REG_ADDR && d[15:14] == 2'b00));
    ok = live && crcok && !stopbad;
    if (live && !crcok) m_crc_fail = 1;
    if (live && crcok && stopbad) m_spi_fail = 1;
    if (ok && clr && a == DEV_STAT_ADDR) {m_crc_fail, m_spi_fail} = 2'b00;
    if (live) begin
      chk_val("err", m_err, err);
      chk_val("sdo", er, rsp);
    end
    m_err = 0;
    chk_val("cmd count", ok, 32'(ncmd - n0));
    if (ok) chk_cmd({1'b1, wr, clr, a, d}, last_cmd);
    chk_val("crc_fail", m_crc_fail, crc_fail);
    chk_val("spi_fail", m_spi_fail, spi_fail);
  endtask

  task automatic set_mode(input spfc_mode_t m);
    int c0, s0;
    c0 = nchg;
    s0 = nslp;
    @(posedge i_mclk) #1 i_mode = m;
    repeat (6) @(posedge i_mclk);
    chk_val("mode_chg", 1, 32'(nchg - c0));
    chk_val("sleep_entry", m == MD_SLEEP, 32'(nslp - s0));
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    logic [6:0] al [12] = '{7'h00, 7'h01, 7'h0B, 7'h0C, 7'h10, 7'h1D,
                            7'h40, 7'h46, 7'h50, 7'h5B, 7'h70, 7'h43};
    logic e;
    logic [31:0] r;
    void'($urandom(80774));
    i_crc_en_pin = 1'b0;
    i_cmd_fail = 1'b0;
    i_mode = MD_INIT;
    i_stat = '0;
    // Falls after time zero so the link toggle surely sees it
    #1 i_rst_b = 1'b0;
    repeat (3) @(posedge i_mclk);
    #1 i_rst_b = 1'b1;
    repeat (5) @(posedge i_mclk);
    chk_val("crc ref a", 32'hC2, crc8(24'h8301F2));
    chk_val("crc ref b", 32'h33, crc8(24'h556B92));
    xfer(7'h05, 1'b1, 16'($urandom), 1'b0);
    set_mode(MD_NORMAL);
    foreach (al[i]) for (int rw = 0; rw < 2; rw++)
      xfer(al[i], rw[0], 16'($urandom), 1'b0);
    $display("test address ranges done");
    xfer(7'h05, 1'b1, 16'h1234, 1'b1);
    xfer(DEV_STAT_ADDR, 1'b0, 16'h0000, 1'b1);
    @(posedge i_mclk) #1 i_cmd_fail = 1'b1;
    @(posedge i_mclk) #1 i_cmd_fail = 1'b0;
    m_spi_fail = 1;
    xfer(7'h40, 1'b0, 16'h0000, 1'b0);
    xfer(DEV_STAT_ADDR, 1'b1, 16'h0000, 1'b0);
    $display("test pattern and flags done");
    @(posedge i_mclk) #1 i_crc_en_pin = 1'b1;
    repeat (6) @(posedge i_mclk);
    chk_val("crc_stat", 1, crc_stat);
    for (int i = 0; i < 4; i++)
      xfer(7'h12, 1'b1, 16'($urandom), i[0]);
    xfer(DEV_STAT_ADDR, 1'b0, 16'h0000, 1'b1);
    xfer(DEV_STAT_ADDR, 1'b1, 16'h0000, 1'b0);
    $display("test crc done");
    set_mode(MD_STOP);
    xfer(7'h05, 1'b1, 16'h00FF, 1'b0);
    xfer(WDOG_REG_ADDR, 1'b1, 16'h0055, 1'b0);
    xfer(MODE_REG_ADDR, 1'b1, 16'h8000, 1'b0);
    xfer(MODE_REG_ADDR, 1'b1, 16'h0000, 1'b0);
    xfer(7'h50, 1'b1, 16'h0000, 1'b0);
    xfer(DEV_STAT_ADDR, 1'b1, 16'h0000, 1'b0);
    $display("test stop done");
    set_mode(MD_RESTART);
    xfer(7'h05, 1'b1, 16'h0F0F, 1'b0);
    set_mode(MD_SLEEP);
    xfer(7'h05, 1'b1, 16'h0F0F, 1'b0);
    set_mode(MD_FAILSAFE);
    xfer(7'h05, 1'b1, 16'h0F0F, 1'b0);
    set_mode(MD_NORMAL);
    $display("test restart and sleep done");
    #1 spfc_host_i.frame(32'h0000_0085, 10, e, r);
    repeat (20) @(posedge i_mclk);
    chk_val("short err", 0, e);
    #1 spfc_host_i.frame(32'h0, 0, e, r);
    repeat (20) @(posedge i_mclk);
    chk_val("peek err", 1, e);
    m_err = 1;
    xfer(7'h05, 1'b0, 16'h0000, 1'b0);
    xfer(7'h05, 1'b0, 16'h0000, 1'b0);
    $display("test short frame done");
    final_report();
  end
endmodule // tb
